// *** bai_defs.svh ***
// Constants for the byte ALU instruction subset.
// Assumes inclusion by bare name from the core and checker modules.
`ifndef BAI_DEFS_SVH
`define BAI_DEFS_SVH

// ----------------------------------------
// Status register location and flag bits
// ----------------------------------------
`define BAI_STATUS_ADDR 5'h03
`define BAI_FLAG_Z      2
`define BAI_FLAG_NC     1
`define BAI_FLAG_C      0

// ----------------------------------------
// Direction register selectors and reset values
// ----------------------------------------
`define BAI_DIR_SEL_A   5'h06
`define BAI_DIR_SEL_B   5'h07
`define BAI_DIR_RESET   8'hff
`define BAI_ACC_RESET   8'h00
`define BAI_FILE_RESET  8'h00

`endif

// *** bai_pkg.sv ***
// Types for the byte ALU instruction subset.
// Assumes bai_defs.svh is on the include path.
package bai_pkg;

   // ----------------------------------------
   // Operation codes presented by the decoder
   // ----------------------------------------
   typedef enum logic [3:0] {
      BAI_OP_IDLE = 4'h0,
      BAI_OP_ADDF = 4'h1,
      BAI_OP_ANDF = 4'h2,
      BAI_OP_XORF = 4'h3,
      BAI_OP_ANDL = 4'h4,
      BAI_OP_XORL = 4'h5,
      BAI_OP_BCLR = 4'h6,
      BAI_OP_BSET = 4'h7,
      BAI_OP_BTSC = 4'h8,
      BAI_OP_DIR  = 4'h9
   } bai_op_t;

   // ----------------------------------------
   // One decoded instruction
   // ----------------------------------------
   typedef struct packed {
      bai_op_t    op;
      logic [4:0] faddr;
      logic       dest;
      logic [2:0] bitsel;
      logic [7:0] lit;
   } bai_instr_t;

   // ----------------------------------------
   // Execute-stage states
   // ----------------------------------------
   typedef enum logic [1:0] {
      BAI_ST_RUN  = 2'b01,
      BAI_ST_SKIP = 2'b10
   } bai_state_t;

endpackage

// *** bai_logic_unit.sv ***
// Combinational arithmetic and logic for the byte ALU.
// Assumes operands are stable for the cycle in which they are used.
`timescale 1ns/10ps
module bai_logic_unit
   import bai_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire bai_op_t          i_op,
   input  wire logic [WIDTH-1:0] i_acc,
   input  wire logic [WIDTH-1:0] i_opnd,
   output logic      [WIDTH-1:0] o_res,
   output logic                  o_carry,
   output logic                  o_nib_carry,
   output logic                  o_zero
);

   logic [WIDTH:0] sum;
   logic [4:0]     nib;

   // ----------------------------------------
   // Operation select
   // ----------------------------------------
   // Sum is one bit wider so the carry out is kept, low nibble separately.
   always_comb begin
      sum         = {1'b0, i_acc} + {1'b0, i_opnd};
      nib         = {1'b0, i_acc[3:0]} + {1'b0, i_opnd[3:0]};
      o_carry     = 1'b0;
      o_nib_carry = 1'b0;
      case (i_op)
         BAI_OP_ADDF: begin
            o_res       = sum[WIDTH-1:0];
            o_carry     = sum[WIDTH];
            o_nib_carry = nib[4];
         end
         BAI_OP_ANDF, BAI_OP_ANDL: o_res = i_acc & i_opnd;
         BAI_OP_XORF, BAI_OP_XORL: o_res = i_acc ^ i_opnd;
         default: o_res = i_acc;
      endcase
      o_zero = (o_res == '0);
   end

endmodule

// *** bai_bit_unit.sv ***
// Bit set, clear and test on one byte.
// Assumes the bit index is in range for the width.
`timescale 1ns/10ps
module bai_bit_unit #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0]         i_val,
   input  wire logic [$clog2(WIDTH)-1:0] i_sel,
   input  wire logic                     i_set,
   output logic      [WIDTH-1:0]         o_val,
   output logic                          o_bit
);

   // ----------------------------------------
   // Bit modify and test
   // ----------------------------------------
   // Only the selected bit changes; the rest pass through.
   always_comb begin
      o_val        = i_val;
      o_val[i_sel] = i_set;
      o_bit        = i_val[i_sel];
   end

endmodule

// *** bai_core.sv ***
// Execute stage of a byte-wide accumulator machine for a subset of operations.
// Assumes a decoder presents one instruction per cycle with a valid strobe.
//
// Function
// - Add accumulator to file, update all flags.
// - Destination 0 accumulator, 1 file register.
// - Bit clear zeroes selected bit, flags kept.
// - Bit set forces selected bit, flags kept.
// - AND immediate into accumulator, zero flag only.
// - AND accumulator with file, zero only.
// - Test bit, skip next when clear.
// - Skip discards fetched instruction, runs no-op.
// - Direction load copies accumulator, flags kept.
// - XOR immediate into accumulator, zero only.
// - XOR accumulator with file, zero only.
// - Zero flag bit 2 set on zero result.
// - Digit carry from low nibble on addition.
// - Status destination keeps flags from result.
`timescale 1ns/10ps
`include "bai_defs.svh"
module bai_core
   import bai_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             I_CLK_SYS,
   input  wire logic             I_RESETN,
   input  wire logic             I_INSTR_VALID,
   input  wire bai_instr_t       I_INSTR,
   output logic                  O_SKIP_ACTIVE,
   output logic                  O_RETIRED,
   output logic      [WIDTH-1:0] O_ACC,
   output logic      [WIDTH-1:0] O_STATUS,
   output logic      [WIDTH-1:0] O_DIR_A,
   output logic      [WIDTH-1:0] O_DIR_B
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] file_r [DEPTH];
   logic [WIDTH-1:0] acc_r;
   logic [WIDTH-1:0] dir_a_r;
   logic [WIDTH-1:0] dir_b_r;
   bai_state_t       state_r;
   bai_state_t       state_nxt;
   logic             retired_r;

   logic [WIDTH-1:0] opnd;
   logic [WIDTH-1:0] fval;
   logic [WIDTH-1:0] alu_res;
   logic             alu_c;
   logic             alu_nc;
   logic             alu_z;
   logic [WIDTH-1:0] bit_val;
   logic             bit_now;
   logic             exec;
   logic             is_file_op;
   logic             is_bit_op;
   logic             flags_z;
   logic             flags_all;
   logic             file_we;
   logic [WIDTH-1:0] file_wdata;
   logic             to_status;

   // ----------------------------------------
   // Operand fetch and datapath units
   // ----------------------------------------
   // A skipped slot executes nothing, which is the no-operation.
   assign exec = I_INSTR_VALID && (state_r == BAI_ST_RUN);
   assign fval = file_r[I_INSTR.faddr[AW-1:0]];
   assign opnd = (I_INSTR.op == BAI_OP_ANDL || I_INSTR.op == BAI_OP_XORL) ? I_INSTR.lit : fval;

   bai_logic_unit #(.WIDTH(WIDTH)) u_logic (
      .i_op        (I_INSTR.op),
      .i_acc       (acc_r),
      .i_opnd      (opnd),
      .o_res       (alu_res),
      .o_carry     (alu_c),
      .o_nib_carry (alu_nc),
      .o_zero      (alu_z)
   );

   bai_bit_unit #(.WIDTH(WIDTH)) u_bit (
      .i_val (fval),
      .i_sel (I_INSTR.bitsel),
      .i_set (I_INSTR.op == BAI_OP_BSET),
      .o_val (bit_val),
      .o_bit (bit_now)
   );

   // ----------------------------------------
   // Write-back decode
   // ----------------------------------------
   always_comb begin
      is_file_op = (I_INSTR.op == BAI_OP_ADDF) || (I_INSTR.op == BAI_OP_ANDF) ||
                   (I_INSTR.op == BAI_OP_XORF);
      is_bit_op  = (I_INSTR.op == BAI_OP_BCLR) || (I_INSTR.op == BAI_OP_BSET);
      flags_all  = exec && (I_INSTR.op == BAI_OP_ADDF);
      flags_z    = exec && (is_file_op || I_INSTR.op == BAI_OP_ANDL ||
                            I_INSTR.op == BAI_OP_XORL);
      file_we    = exec && ((is_file_op && I_INSTR.dest) || is_bit_op);
      file_wdata = is_bit_op ? bit_val : alu_res;
      to_status  = (I_INSTR.faddr == `BAI_STATUS_ADDR);
   end

   // ----------------------------------------
   // File registers
   // ----------------------------------------
   // All three flag bits of the status entry are shielded from the write-back of
   // a flag-affecting op; they follow the result instead, so carry and nibble
   // carry survive a logic op aimed at the status entry.
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         for (int i = 0; i < DEPTH; i++) begin
            file_r[i] <= `BAI_FILE_RESET;
         end
      end else begin
         if (file_we && !(to_status && flags_z)) begin
            file_r[I_INSTR.faddr[AW-1:0]] <= file_wdata;
         end else if (file_we) begin
            file_r[`BAI_STATUS_ADDR][WIDTH-1:3] <= file_wdata[WIDTH-1:3];
         end
         if (flags_z) begin
            file_r[`BAI_STATUS_ADDR][`BAI_FLAG_Z] <= alu_z;
         end
         if (flags_all) begin
            file_r[`BAI_STATUS_ADDR][`BAI_FLAG_C]  <= alu_c;
            file_r[`BAI_STATUS_ADDR][`BAI_FLAG_NC] <= alu_nc;
         end
      end
   end

   // ----------------------------------------
   // Accumulator
   // ----------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         acc_r <= `BAI_ACC_RESET;
      end else if (exec && (I_INSTR.op == BAI_OP_ANDL || I_INSTR.op == BAI_OP_XORL)) begin
         acc_r <= alu_res;
      end else if (exec && is_file_op && !I_INSTR.dest) begin
         acc_r <= alu_res;
      end
   end

   // ----------------------------------------
   // Pin direction registers
   // ----------------------------------------
   // Other operand values are ignored rather than trapped.
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         dir_a_r <= `BAI_DIR_RESET;
         dir_b_r <= `BAI_DIR_RESET;
      end else if (exec && I_INSTR.op == BAI_OP_DIR) begin
         if (I_INSTR.faddr == `BAI_DIR_SEL_A) begin
            dir_a_r <= acc_r;
         end
         if (I_INSTR.faddr == `BAI_DIR_SEL_B) begin
            dir_b_r <= acc_r;
         end
      end
   end

   // ----------------------------------------
   // Skip sequencer
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         BAI_ST_RUN: begin
            if (exec && I_INSTR.op == BAI_OP_BTSC && !bit_now) begin
               state_nxt = BAI_ST_SKIP;
            end
         end
         BAI_ST_SKIP: begin
            if (I_INSTR_VALID) begin
               state_nxt = BAI_ST_RUN;
            end
         end
         default: state_nxt = BAI_ST_RUN;
      endcase
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         state_r <= BAI_ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------
   // Retire strobe
   // ----------------------------------------
   // Pulses for each instruction that executed, not for a discarded one.
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         retired_r <= 1'b0;
      end else begin
         retired_r <= exec;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign O_SKIP_ACTIVE = (state_r == BAI_ST_SKIP);
   assign O_RETIRED     = retired_r;
   assign O_ACC         = acc_r;
   assign O_STATUS      = file_r[`BAI_STATUS_ADDR];
   assign O_DIR_A       = dir_a_r;
   assign O_DIR_B       = dir_b_r;

endmodule

// *** bai_core_checker.sv ***
// Concurrent checks on the ports of the byte ALU execute stage.
// Assumes it is bound to bai_core and sees only its ports.
`timescale 1ns/10ps
`include "bai_defs.svh"
module bai_core_checker
   import bai_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             I_CLK_SYS,
   input  wire logic             I_RESETN,
   input  wire logic             I_INSTR_VALID,
   input  wire bai_instr_t       I_INSTR,
   input  wire logic             O_SKIP_ACTIVE,
   input  wire logic             O_RETIRED,
   input  wire logic [WIDTH-1:0] O_ACC,
   input  wire logic [WIDTH-1:0] O_STATUS,
   input  wire logic [WIDTH-1:0] O_DIR_A,
   input  wire logic [WIDTH-1:0] O_DIR_B
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   logic             take;
   logic [WIDTH-1:0] and_v;
   logic [WIDTH-1:0] xor_v;
   logic             to_stat;
   // Expected immediate results, sampled one cycle later through $past.
   assign take    = I_INSTR_VALID && !O_SKIP_ACTIVE;
   assign and_v   = O_ACC & I_INSTR.lit;
   assign xor_v   = O_ACC ^ I_INSTR.lit;
   assign to_stat = I_INSTR.faddr == `BAI_STATUS_ADDR;

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESETN);

   property p_retire; take |=> O_RETIRED; endproperty
   a_retire: assert property (p_retire) else $error("executed instruction did not retire");
   property p_discard; I_INSTR_VALID && O_SKIP_ACTIVE |=> !O_RETIRED && !O_SKIP_ACTIVE && $stable(O_ACC); endproperty
   a_discard: assert property (p_discard) else $error("skipped instruction was not discarded");
   property p_skip_src; $rose(O_SKIP_ACTIVE) |-> $past(take) && $past(I_INSTR.op) == BAI_OP_BTSC; endproperty
   a_skip_src: assert property (p_skip_src) else $error("skip began without a bit test");
   property p_and_imm;
      take && I_INSTR.op == BAI_OP_ANDL |=> O_ACC == $past(and_v) && O_STATUS[`BAI_FLAG_Z] == (O_ACC == '0)
         && $stable(O_STATUS[1:0]);
   endproperty
   a_and_imm: assert property (p_and_imm) else $error("immediate AND result or flags wrong");
   property p_xor_imm;
      take && I_INSTR.op == BAI_OP_XORL |=> O_ACC == $past(xor_v) && O_STATUS[`BAI_FLAG_Z] == (O_ACC == '0)
         && $stable(O_STATUS[1:0]);
   endproperty
   a_xor_imm: assert property (p_xor_imm) else $error("immediate XOR result or flags wrong");
   property p_logic_file;
      take && I_INSTR.op inside {BAI_OP_ANDF, BAI_OP_XORF} |=> $stable(O_STATUS[1:0]);
   endproperty
   a_logic_file: assert property (p_logic_file) else $error("logic op touched carry flags");
   property p_zero_acc;
      take && I_INSTR.op inside {BAI_OP_ADDF, BAI_OP_ANDF, BAI_OP_XORF} && !I_INSTR.dest
         |=> O_STATUS[`BAI_FLAG_Z] == (O_ACC == '0);
   endproperty
   a_zero_acc: assert property (p_zero_acc) else $error("zero flag disagrees with result");
   property p_dest_file;
      take && I_INSTR.op inside {BAI_OP_ADDF, BAI_OP_ANDF, BAI_OP_XORF} && I_INSTR.dest |=> $stable(O_ACC);
   endproperty
   a_dest_file: assert property (p_dest_file) else $error("file destination changed accumulator");
   property p_bits_keep;
      take && I_INSTR.op inside {BAI_OP_BCLR, BAI_OP_BSET} && !to_stat |=> $stable(O_STATUS) && $stable(O_ACC);
   endproperty
   a_bits_keep: assert property (p_bits_keep) else $error("bit op changed flags");
   property p_dir_a;
      take && I_INSTR.op == BAI_OP_DIR && I_INSTR.faddr == `BAI_DIR_SEL_A
         |=> O_DIR_A == $past(O_ACC) && $stable(O_DIR_B) && $stable(O_STATUS);
   endproperty
   a_dir_a: assert property (p_dir_a) else $error("direction A load wrong");
   property p_dir_b;
      take && I_INSTR.op == BAI_OP_DIR && I_INSTR.faddr == `BAI_DIR_SEL_B
         |=> O_DIR_B == $past(O_ACC) && $stable(O_DIR_A) && $stable(O_STATUS);
   endproperty
   a_dir_b: assert property (p_dir_b) else $error("direction B load wrong");

   c_skip: cover property (take && I_INSTR.op == BAI_OP_BTSC ##1 O_SKIP_ACTIVE);
   c_carry: cover property (take && I_INSTR.op == BAI_OP_ADDF ##1 O_STATUS[`BAI_FLAG_C]);
   c_dir: cover property (take && I_INSTR.op == BAI_OP_DIR);
endmodule

// *** bai_core_tb.sv ***
// Self-checking bench for the byte ALU execute stage.
// Assumes bai_core, its package and the checker are compiled first.
`timescale 1ns/10ps
module bai_core_tb
   import bai_pkg::*;
;
   logic       clk;
   logic       resetn;
   logic       valid;
   bai_instr_t instr;
   logic       skip;
   logic       retired;
   logic [7:0] acc;
   logic [7:0] status;
   logic [7:0] dir_a;
   logic [7:0] dir_b;
   int         failures;
   int         check_count;

   bai_core DUT (.I_CLK_SYS(clk), .I_RESETN(resetn), .I_INSTR_VALID(valid), .I_INSTR(instr),
      .O_SKIP_ACTIVE(skip), .O_RETIRED(retired), .O_ACC(acc), .O_STATUS(status), .O_DIR_A(dir_a), .O_DIR_B(dir_b));

   // ----------------------------------------
   // Driver and comparison tasks
   // ----------------------------------------
   // Wide enough for the packed groups of outputs compared in one call.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Valid stays high so back-to-back calls never assign it twice in one step.
   task automatic run(input bai_op_t op, input logic [4:0] f, input logic d, input logic [2:0] b, input logic [7:0] k);
      instr = '{op, f, d, b, k};
      valid = 1'b1;
      @(posedge clk);
      #1;
   endtask
   task automatic fin(input string s);
      valid = 1'b0;
      @(posedge clk);
      #1;
      $display("test %s done", s);
   endtask
   task automatic setw(input logic [7:0] k);
      run(BAI_OP_ANDL, 5'h00, 1'b0, 3'h0, 8'h00);
      run(BAI_OP_XORL, 5'h00, 1'b0, 3'h0, k);
   endtask
   task automatic rd(input logic [4:0] f);
      run(BAI_OP_ANDL, 5'h00, 1'b0, 3'h0, 8'h00);
      run(BAI_OP_ADDF, f, 1'b0, 3'h0, 8'h00);
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_arith();
      chk({acc, status}, 16'h0000);
      chk({dir_a, dir_b}, 16'hffff);
      setw(8'h5a);
      chk({acc, status, 7'h0, retired}, 24'h5a0001);
      run(BAI_OP_ANDL, 5'h00, 1'b0, 3'h0, 8'hf0);
      chk({acc, status}, 16'h5000);
      run(BAI_OP_ANDL, 5'h00, 1'b0, 3'h0, 8'h0f);
      chk({acc, status}, 16'h0004);
      setw(8'h8f);
      run(BAI_OP_ADDF, 5'h05, 1'b1, 3'h0, 8'h00);
      chk({acc, status}, 16'h8f00);
      run(BAI_OP_ADDF, 5'h05, 1'b0, 3'h0, 8'h00);
      chk({acc, status}, 16'h1e03);
      setw(8'h80);
      chk(status, 8'h03);
      run(BAI_OP_ADDF, 5'h06, 1'b1, 3'h0, 8'h00);
      run(BAI_OP_ADDF, 5'h06, 1'b0, 3'h0, 8'h00);
      chk({acc, status}, 16'h0005);
      fin("arith");
   endtask
   task automatic t_logic();
      setw(8'h3c);
      run(BAI_OP_XORF, 5'h06, 1'b1, 3'h0, 8'h00);
      run(BAI_OP_ANDF, 5'h06, 1'b0, 3'h0, 8'h00);
      chk({acc, status}, 16'h3c01);
      run(BAI_OP_XORF, 5'h06, 1'b0, 3'h0, 8'h00);
      chk({acc, status}, 16'h8001);
      rd(5'h06);
      chk({acc, status}, 16'hbc00);
      run(BAI_OP_ANDL, 5'h00, 1'b0, 3'h0, 8'h00);
      run(BAI_OP_BSET, 5'h09, 1'b0, 3'h7, 8'h00);
      run(BAI_OP_BSET, 5'h09, 1'b0, 3'h0, 8'h00);
      chk(status, 8'h04);
      rd(5'h09);
      chk(acc, 8'h81);
      run(BAI_OP_BCLR, 5'h09, 1'b0, 3'h7, 8'h00);
      rd(5'h09);
      chk(acc, 8'h01);
      fin("logic");
   endtask
   task automatic t_skip_dir();
      run(BAI_OP_BTSC, 5'h09, 1'b0, 3'h3, 8'h00);
      chk({7'h0, skip, 7'h0, retired}, 16'h0101);
      run(BAI_OP_XORL, 5'h00, 1'b0, 3'h0, 8'hff);
      chk({acc, 7'h0, skip, 7'h0, retired}, 24'h010000);
      run(BAI_OP_BTSC, 5'h09, 1'b0, 3'h0, 8'h00);
      chk({7'h0, skip}, 8'h00);
      run(BAI_OP_XORL, 5'h00, 1'b0, 3'h0, 8'h0f);
      chk({acc, 7'h0, retired}, 16'h0e01);
      setw(8'ha5);
      run(BAI_OP_DIR, 5'h06, 1'b0, 3'h0, 8'h00);
      run(BAI_OP_DIR, 5'h05, 1'b0, 3'h0, 8'h00);
      chk({dir_a, dir_b, status}, 24'ha5ff00);
      setw(8'h3c);
      run(BAI_OP_DIR, 5'h07, 1'b0, 3'h0, 8'h00);
      chk({dir_a, dir_b}, 16'ha53c);
      fin("skip_dir");
   endtask
   task automatic t_status_dest();
      rd(5'h0a);
      chk(status, 8'h04);
      run(BAI_OP_XORL, 5'h00, 1'b0, 3'h0, 8'hfc);
      run(BAI_OP_ADDF, 5'h03, 1'b1, 3'h0, 8'h00);
      chk({acc, status}, 16'hfcf8);
      run(BAI_OP_XORF, 5'h03, 1'b1, 3'h0, 8'h00);
      chk(status, 8'h00);
      setw(8'h07);
      run(BAI_OP_XORF, 5'h03, 1'b1, 3'h0, 8'h00);
      chk({acc, status}, 16'h0700);
      fin("status_dest");
   endtask

   // ----------------------------------------
   // Clock, reset, sequence and watchdog
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      resetn = 1'b0;
      valid = 1'b0;
      instr = '0;
      failures = 0;
      check_count = 0;
      repeat (3) @(posedge clk);
      #1;
      resetn = 1'b1;
      t_arith();
      t_logic();
      t_skip_dir();
      t_status_dest();
      stop_test();
   end
   // The whole run is well under a hundred cycles, so this only trips on a hang.
   initial begin
      #4000;
      failures++;
      stop_test();
   end
endmodule

bind bai_core bai_core_checker #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN),
   .I_INSTR_VALID(I_INSTR_VALID), .I_INSTR(I_INSTR), .O_SKIP_ACTIVE(O_SKIP_ACTIVE), .O_RETIRED(O_RETIRED),
   .O_ACC(O_ACC), .O_STATUS(O_STATUS), .O_DIR_A(O_DIR_A), .O_DIR_B(O_DIR_B));
